// file: hdl/hscl_regs.vh
// register map, field positions and reset values of the status/clock block
`ifndef HSCL_REGS_VH
`define HSCL_REGS_VH

// word indexes; byte address is four times the index
`define HSCL_IDX_STATUS 8'h14
`define HSCL_IDX_CLKCTL 8'h15
`define HSCL_IDX_IRQ_STAT 8'h20
`define HSCL_IDX_IRQ_MASK 8'h21

// status register layout
`define HSCL_ST_MAIN_OVR 0
`define HSCL_ST_MAIN_UND 1
`define HSCL_ST_ALT_OVR 2
`define HSCL_ST_ALT_UND 3
`define HSCL_ST_TX0 8
`define HSCL_ST_TX1 9
`define HSCL_ST_RX0 10
`define HSCL_ST_RX1 11
`define HSCL_ST_TX2 12
`define HSCL_ST_TX3 13
`define HSCL_ST_RX2 14
`define HSCL_ST_RX3 15
`define HSCL_STATUS_RST 16'h0000

// clock output control layout
`define HSCL_CC_EN 9
`define HSCL_CC_SLEEP 8
`define HSCL_CC_DIV_HI 7
`define HSCL_CC_DIV_LO 4
`define HSCL_CC_SEL_HI 3
`define HSCL_CC_SEL_LO 0
`define HSCL_CC_RST 10'h280
`define HSCL_MASK_RST 16'h0000

// divide codes
`define HSCL_DIV_1 4'h0
`define HSCL_DIV_2 4'h4
`define HSCL_DIV_4 4'h8
`define HSCL_DIV_16 4'h9
`define HSCL_DIV_5 4'hc
`define HSCL_DIV_10 4'hd
`define HSCL_DIV_20 4'he
`define HSCL_DIV_25 4'hf

// clock source indexes on the source bus
`define HSCL_SRC_A_RX 3'h0
`define HSCL_SRC_A_TX 3'h1
`define HSCL_SRC_L03_RX 3'h2
`define HSCL_SRC_L03_TX 3'h3
`define HSCL_SRC_B_RX 3'h4
`define HSCL_SRC_B_TX 3'h5
`define HSCL_SRC_L47_RX 3'h6

`endif

// file: hdl/hscl_flag_latch.v
// latched-high status flags with pin synchronisers
`timescale 1ns/1ps
module hscl_flag_latch #(
  parameter W = 16
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // raw conditions from pins and same-domain qualifiers
  input wire [W-1:0] cond_pin,
  input wire [W-1:0] qual,
  // clear request for flags that software has just read
  input wire [W-1:0] clr,
  // latched flags and one-cycle set events
  output reg [W-1:0] flag_reg,
  output reg [W-1:0] set_ev_reg
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  wire [W-1:0] live;
  wire [W-1:0] flag_next;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_sync
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= cond_pin[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign live = sync_reg & qual;
  // a live condition beats the clear, so nothing is lost on a read
  assign flag_next = (flag_reg & ~clr) | live;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_reg <= {W{1'b0}};
      set_ev_reg <= {W{1'b0}};
    end else begin
      flag_reg <= flag_next;
      set_ev_reg <= flag_next & ~flag_reg;
    end
  end
endmodule // hscl_flag_latch

// file: hdl/hscl_clk_gen.v
// clock output source select, divider, enable and sleep
`timescale 1ns/1ps
`include "hscl_regs.vh"
module hscl_clk_gen #(
  parameter NSRC = 7
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // candidate byte clocks from the pins
  input wire [NSRC-1:0] src_pin,
  // control fields
  input wire [3:0] sel,
  input wire [3:0] div,
  input wire en,
  input wire sleep,
  // differential output and power state
  output reg out_p_reg,
  output reg out_n_reg,
  output reg awake_reg
);
  reg [NSRC-1:0] meta_reg;
  reg [NSRC-1:0] sync_reg;
  reg last_reg;
  reg [4:0] cnt_reg;
  reg [2:0] src_idx;
  reg [4:0] ratio;
  reg level;
  reg phase;

  genvar i;
  generate
    for (i = 0; i < NSRC; i = i + 1) begin : g_sync
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= src_pin[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  always @* begin
    // unlisted or doubtful codes fall back to macro A recovered clock
    src_idx = `HSCL_SRC_A_RX;
    if (sel[3:2] == 2'b00 && sel[0] == 1'b0)
      src_idx = `HSCL_SRC_A_RX;
    else if (sel[3:2] == 2'b00)
      src_idx = `HSCL_SRC_A_TX;
    else if (sel == 4'h6)
      src_idx = `HSCL_SRC_L03_RX;
    else if (sel == 4'h7)
      src_idx = `HSCL_SRC_L03_TX;
    else if (sel[3:2] == 2'b10 && sel[0] == 1'b0)
      src_idx = `HSCL_SRC_B_RX;
    else if (sel[3:2] == 2'b10)
      src_idx = `HSCL_SRC_B_TX;
    else if (sel == 4'he)
      src_idx = `HSCL_SRC_L47_RX;
    level = sync_reg[src_idx];
    case (div)
      `HSCL_DIV_1: ratio = 5'd1;
      `HSCL_DIV_2: ratio = 5'd2;
      `HSCL_DIV_4: ratio = 5'd4;
      `HSCL_DIV_16: ratio = 5'd16;
      `HSCL_DIV_5: ratio = 5'd5;
      `HSCL_DIV_10: ratio = 5'd10;
      `HSCL_DIV_20: ratio = 5'd20;
      `HSCL_DIV_25: ratio = 5'd25;
      default: ratio = 5'd4;
    endcase
    phase = (ratio == 5'd1) ? level : (cnt_reg < (ratio >> 1));
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg <= 1'b0;
      cnt_reg <= 5'd0;
      out_p_reg <= 1'b0;
      out_n_reg <= 1'b0;
      awake_reg <= 1'b0;
    end else begin
      last_reg <= level;
      if (level && !last_reg)
        cnt_reg <= (cnt_reg >= ratio - 5'd1) ? 5'd0 : cnt_reg + 5'd1;
      awake_reg <= ~sleep;
      if (sleep) begin
        // powered down: both legs released low
        out_p_reg <= 1'b0;
        out_n_reg <= 1'b0;
      end else if (!en) begin
        out_p_reg <= 1'b0;
        out_n_reg <= 1'b1;
      end else begin
        out_p_reg <= phase;
        out_n_reg <= ~phase;
      end
    end
  end
endmodule // hscl_clk_gen

// file: hdl/hscl_top.v
// status register and clock output control behind an apb slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "hscl_regs.vh"
module hscl_top (
  // clock and reset
  input wire clk,
  input wire rst,

  // apb slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,

  // lane alignment indications from the datapaths
  input wire tx_group0_aligned,
  input wire tx_group1_aligned,
  input wire tx_group2_aligned,
  input wire tx_group3_aligned,
  input wire rx_group0_aligned,
  input wire rx_group1_aligned,
  input wire rx_group2_aligned,
  input wire rx_group3_aligned,

  // receive fifo fault indications
  input wire main_rx_fifo_overrun,
  input wire main_rx_fifo_underrun,
  input wire alt_rx_fifo_overrun,
  input wire alt_rx_fifo_underrun,
  input wire alt_rx_selected,

  // candidate byte clocks
  input wire macro_a_rx_byte_clk,
  input wire macro_a_tx_byte_clk,
  input wire lanes03_rx_byte_clk,
  input wire lanes03_tx_byte_clk,
  input wire macro_b_rx_byte_clk,
  input wire macro_b_tx_byte_clk,
  input wire lanes47_rx_byte_clk,

  // clock output pins and power state
  output reg clock_output_pins_p,
  output reg clock_output_pins_n,
  output reg clock_output_awake,

  // interrupt
  output reg irq
);

  // apb phase, one-hot: idle or answering
  localparam [1:0] APB_IDLE = 2'b01;
  localparam [1:0] APB_ANSWER = 2'b10;
  reg [1:0] apb_state_reg;
  reg [1:0] apb_state_next;
  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  wire access;
  wire done;

  // decode
  reg hit_status;
  reg hit_ctl;
  reg hit_ist;
  reg hit_imask;
  reg mapped;

  // registers
  reg [9:0] clkctl_reg;
  reg [9:0] clkctl_next;
  reg [15:0] ist_reg;
  reg [15:0] ist_next;
  reg [15:0] imask_reg;
  reg [15:0] imask_next;
  reg irq_reg;

  // alternate source qualifier, two-stage synchroniser
  reg alt_meta_reg;
  reg alt_sync_reg;

  // status flags
  wire [15:0] cond_pin;
  wire [15:0] qual;
  wire [15:0] status_flags;
  wire [15:0] status_events;
  reg [15:0] status_clr;

  // read mux
  reg [31:0] rdata_next;

  // clock generator outputs
  wire gen_p;
  wire gen_n;
  wire gen_awake;

  // completion strobes, one per register action
  wire wr_done;
  wire rd_done;
  wire wr_ctl;
  wire wr_ist;
  wire wr_imask;
  wire rd_status;
  wire [15:0] irq_pend;

  // a request is answered one cycle after its first access cycle
  assign access = psel & penable & (apb_state_reg == APB_IDLE);
  assign done = psel & penable & (apb_state_reg == APB_ANSWER);

  // state changes only on the completing edge, so a request that the
  // master abandons before pready leaves every register untouched
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign wr_ctl = wr_done & hit_ctl;
  assign wr_ist = wr_done & hit_ist;
  assign wr_imask = wr_done & hit_imask;
  assign rd_status = rd_done & hit_status;

  // apb state: pready stands one cycle, then the slave is idle again
  always @* begin
    apb_state_next = apb_state_reg;
    case (apb_state_reg)
      APB_IDLE: begin
        if (access)
          apb_state_next = APB_ANSWER;
      end
      APB_ANSWER: begin
        apb_state_next = APB_IDLE;
      end
      default: begin
        apb_state_next = APB_IDLE;
      end
    endcase
  end

  // address decode
  always @* begin
    hit_status = 1'b0;
    hit_ctl = 1'b0;
    hit_ist = 1'b0;
    hit_imask = 1'b0;
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      hit_status = 1'b0;
    end else if (paddr[9:2] == `HSCL_IDX_STATUS) begin
      hit_status = 1'b1;
    end else if (paddr[9:2] == `HSCL_IDX_CLKCTL) begin
      hit_ctl = 1'b1;
    end else if (paddr[9:2] == `HSCL_IDX_IRQ_STAT) begin
      hit_ist = 1'b1;
    end else if (paddr[9:2] == `HSCL_IDX_IRQ_MASK) begin
      hit_imask = 1'b1;
    end
    mapped = hit_status | hit_ctl | hit_ist | hit_imask;
  end

  // read data
  always @* begin
    rdata_next = 32'h0000_0000;
    if (hit_status) begin
      rdata_next = {16'h0000, status_flags};
    end else if (hit_ctl) begin
      rdata_next = {22'h00_0000, clkctl_reg};
    end else if (hit_ist) begin
      rdata_next = {16'h0000, ist_reg};
    end else if (hit_imask) begin
      rdata_next = {16'h0000, imask_reg};
    end
  end

  // apb answer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      apb_state_reg <= APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      apb_state_reg <= apb_state_next;
      pready_reg <= (apb_state_next == APB_ANSWER);
      if (access) begin
        pslverr_reg <= ~mapped;
        prdata_reg <= pwrite ? 32'h0000_0000 : rdata_next;
      end else if (done) begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always @* begin
    pready = pready_reg;
    pslverr = pslverr_reg & pready_reg;
    prdata = prdata_reg;
  end

  // only bits actually returned to software are cleared, so an event
  // landing between capture and completion stays latched
  always @* begin
    status_clr = 16'h0000;
    if (rd_status)
      status_clr = prdata_reg[15:0];
  end

  // alternate source select is a pin level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
    end else begin
      alt_meta_reg <= alt_rx_selected;
      alt_sync_reg <= alt_meta_reg;
    end
  end

  // status bit map
  assign cond_pin[`HSCL_ST_MAIN_OVR] = main_rx_fifo_overrun;
  assign cond_pin[`HSCL_ST_MAIN_UND] = main_rx_fifo_underrun;
  assign cond_pin[`HSCL_ST_ALT_OVR] = alt_rx_fifo_overrun;
  assign cond_pin[`HSCL_ST_ALT_UND] = alt_rx_fifo_underrun;
  assign cond_pin[7:4] = 4'h0;
  assign cond_pin[`HSCL_ST_TX0] = tx_group0_aligned;
  assign cond_pin[`HSCL_ST_TX1] = tx_group1_aligned;
  assign cond_pin[`HSCL_ST_RX0] = rx_group0_aligned;
  assign cond_pin[`HSCL_ST_RX1] = rx_group1_aligned;
  assign cond_pin[`HSCL_ST_TX2] = tx_group2_aligned;
  assign cond_pin[`HSCL_ST_TX3] = tx_group3_aligned;
  assign cond_pin[`HSCL_ST_RX2] = rx_group2_aligned;
  assign cond_pin[`HSCL_ST_RX3] = rx_group3_aligned;

  // alternate fifo faults count only while that source is in use
  assign qual = {12'hfff, alt_sync_reg, alt_sync_reg, 2'b11};

  hscl_flag_latch #(
    .W(16)
  ) u_flags (
    .clk(clk),
    .rst(rst),
    .cond_pin(cond_pin),
    .qual(qual),
    .clr(status_clr),
    .flag_reg(status_flags),
    .set_ev_reg(status_events)
  );

  // clock output control register, only bits 9..0 are stored
  always @* begin
    clkctl_next = clkctl_reg;
    if (wr_ctl) begin
      if (pstrb[0])
        clkctl_next[7:0] = pwdata[7:0];
      if (pstrb[1])
        clkctl_next[9:8] = pwdata[9:8];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst)
      clkctl_reg <= `HSCL_CC_RST;
    else
      clkctl_reg <= clkctl_next;
  end

  // interrupt status: set beats a same-cycle write-one clear
  always @* begin
    ist_next = ist_reg;
    if (wr_ist) begin
      if (pstrb[0])
        ist_next[7:0] = ist_next[7:0] & ~pwdata[7:0];
      if (pstrb[1])
        ist_next[15:8] = ist_next[15:8] & ~pwdata[15:8];
    end
    ist_next = ist_next | status_events;
  end

  always @* begin
    imask_next = imask_reg;
    if (wr_imask) begin
      if (pstrb[0])
        imask_next[7:0] = pwdata[7:0];
      if (pstrb[1])
        imask_next[15:8] = pwdata[15:8];
    end
  end

  // irq is registered from the next values, so it rises with its status bit
  assign irq_pend = ist_next & imask_next;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_reg <= `HSCL_STATUS_RST;
      imask_reg <= `HSCL_MASK_RST;
      irq_reg <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      irq_reg <= |irq_pend;
    end
  end

  always @* begin
    irq = irq_reg;
  end

  // clock output path
  hscl_clk_gen #(
    .NSRC(7)
  ) u_clk (
    .clk(clk),
    .rst(rst),
    .src_pin({lanes47_rx_byte_clk, macro_b_tx_byte_clk,
              macro_b_rx_byte_clk, lanes03_tx_byte_clk,
              lanes03_rx_byte_clk, macro_a_tx_byte_clk,
              macro_a_rx_byte_clk}),
    .sel(clkctl_reg[`HSCL_CC_SEL_HI:`HSCL_CC_SEL_LO]),
    .div(clkctl_reg[`HSCL_CC_DIV_HI:`HSCL_CC_DIV_LO]),
    .en(clkctl_reg[`HSCL_CC_EN]),
    .sleep(clkctl_reg[`HSCL_CC_SLEEP]),
    .out_p_reg(gen_p),
    .out_n_reg(gen_n),
    .awake_reg(gen_awake)
  );

  // pins come straight from the generator's flip-flops
  always @* begin
    clock_output_pins_p = gen_p;
    clock_output_pins_n = gen_n;
    clock_output_awake = gen_awake;
  end

endmodule // hscl_top

// file: bench/hscl_top_properties.sv
// port checks for the status and clock output block
`timescale 1ns/1ps
module hscl_checker (
  // clock and reset
  input logic clk,
  input logic rst,
  // apb
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata,
  input logic pready,
  // status sources
  input logic tx_group3_aligned,
  input logic rx_group0_aligned,
  input logic main_rx_fifo_overrun,
  input logic main_rx_fifo_underrun,
  input logic alt_rx_fifo_underrun,
  input logic alt_rx_selected,
  // clock output
  input logic clock_output_pins_p,
  input logic clock_output_pins_n,
  input logic clock_output_awake
);
  logic [2:0] up_reg;
  logic rd_ok;
  logic st;
  // right after reset a flag may still sit in the synchroniser
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      up_reg <= 3'h0;
    end else if (up_reg != 3'h7) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  assign rd_ok = psel && penable && pready && !pwrite;
  assign st = rd_ok && paddr == 12'h050 && up_reg == 3'h7;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  rx0_flag_a: assert property (
    st && $past(rx_group0_aligned, 2) && $past(rx_group0_aligned, 5)
    |-> prdata[10]) else $error("rx group 0 flag lost");
  tx3_flag_a: assert property (
    st && $past(tx_group3_aligned, 2) && $past(tx_group3_aligned, 5)
    |-> prdata[13]) else $error("tx group 3 flag lost");
  main_under_a: assert property (
    st && $past(main_rx_fifo_underrun, 2)
    && $past(main_rx_fifo_underrun, 5)
    |-> prdata[1]) else $error("main underrun flag lost");
  main_over_a: assert property (
    st && $past(main_rx_fifo_overrun, 2) && $past(main_rx_fifo_overrun, 5)
    |-> prdata[0]) else $error("main overrun flag lost");
  alt_under_a: assert property (
    st && $past(alt_rx_selected, 2) && $past(alt_rx_selected, 5)
    && $past(alt_rx_fifo_underrun, 2) && $past(alt_rx_fifo_underrun, 5)
    |-> prdata[3]) else $error("alt underrun flag lost");
  ctl_reserved_a: assert property (
    rd_ok && paddr == 12'h054 |-> prdata[31:10] == 22'h0)
    else $error("control reserved bits not zero");
  pins_diff_a: assert property (
    clock_output_awake [*2] |-> clock_output_pins_p != clock_output_pins_n)
    else $error("clock pins not complementary");
  sleep_low_a: assert property (
    !clock_output_awake ##1 !clock_output_awake
    |-> !clock_output_pins_p && !clock_output_pins_n)
    else $error("sleeping clock output still driven");
endmodule // hscl_checker

// file: bench/test_hs_status_and_clock_output.sv
// self-checking bench for the status and clock output block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module test_hs_status_and_clock_output;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, alt_sel = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, m;
  logic pready, pslverr, pins_p, pins_n, awake, irq;
  logic [15:0] ev = 16'h0;
  logic [6:0] src = 7'h0;
  logic [33:0] note;
  logic [33:0] expq[$];
  int errors = 0, compares = 0, prise = 0, k;

  always #25 clk = ~clk;
  always @(posedge pins_p) prise++;

  hscl_top i_dut (
    .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .tx_group0_aligned(ev[8]), .tx_group1_aligned(ev[9]),
    .rx_group0_aligned(ev[10]), .rx_group1_aligned(ev[11]),
    .tx_group2_aligned(ev[12]), .tx_group3_aligned(ev[13]),
    .rx_group2_aligned(ev[14]), .rx_group3_aligned(ev[15]),
    .main_rx_fifo_overrun(ev[0]), .main_rx_fifo_underrun(ev[1]),
    .alt_rx_fifo_overrun(ev[2]), .alt_rx_fifo_underrun(ev[3]),
    .alt_rx_selected(alt_sel),
    .macro_a_rx_byte_clk(src[0]), .macro_a_tx_byte_clk(src[1]),
    .lanes03_rx_byte_clk(src[2]), .lanes03_tx_byte_clk(src[3]),
    .macro_b_rx_byte_clk(src[4]), .macro_b_tx_byte_clk(src[5]),
    .lanes47_rx_byte_clk(src[6]), .clock_output_pins_p(pins_p),
    .clock_output_pins_n(pins_n), .clock_output_awake(awake), .irq(irq));

  // note is {write, error expected, read data expected}
  task automatic xfer(input [11:0] a, input w, input [31:0] d,
    input [33:0] e);
    begin
      expq.push_back(e);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
        @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rd(input [11:0] a, input [31:0] e, input err = 1'b0);
    xfer(a, 1'b0, 32'h0, {1'b0, err, e});
  endtask

  task automatic wr(input [11:0] a, input [31:0] d);
    xfer(a, 1'b1, d, {2'b10, 32'h0});
  endtask

  // source toggles at a quarter of clk so the synchroniser can follow it
  task automatic run(input [9:0] c, input int s, input int r, input int e);
    int p0;
    begin
      wr(12'h054, {22'h0, c});
      repeat (4) @(posedge clk);
      p0 = prise;
      repeat (r) begin
        src[s] <= 1'b1;
        repeat (2) @(posedge clk);
        src[s] <= 1'b0;
        repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      `CHK(prise - p0 >= e - 1 && prise - p0 <= e + 1, 1'b1);
    end
  endtask

  // high nibble is the select code, low nibble the source it must route
  task automatic sel_run(input [7:0] t);
    run({6'h20, t[7:4]}, int'(t[3:0]), 8, 8);
  endtask

  task automatic div_run(input [3:0] code, input int n);
    run({2'b10, code, 4'h0}, 0, 100, 100 / n);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
      note = expq.pop_front();
      `CHK(pslverr, note[32]);
      if (!note[33]) `CHK(prdata, note[31:0]);
    end
  end

  task stop_test;
    begin
      if (expq.size() != 0) errors++;
      if (errors == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("MISMATCH %0t timeout", $time);
    stop_test();
  end

  initial begin
    void'($urandom(32'hd390));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(12'h054, 32'h280);
    rd(12'h050, 32'h0);
    rd(12'h084, 32'h0);
    rd(12'h104, 32'h0, 1'b1);
    wr(12'h050, 32'hffff);
    rd(12'h050, 32'h0);
    m = $urandom;
    wr(12'h054, m);
    rd(12'h054, m & 32'h3ff);
    ev[3:2] <= 2'b11;
    repeat (6) @(posedge clk);
    ev[3:2] <= 2'b00;
    repeat (6) @(posedge clk);
    rd(12'h050, 32'h0);
    alt_sel <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      k = i < 8 ? i + 8 : i - 8;
      m = $urandom & 32'hff0f;
      wr(12'h084, m);
      ev[k] <= 1'b1;
      repeat (6) @(posedge clk);
      rd(12'h050, 32'h1 << k);
      rd(12'h050, 32'h1 << k);
      ev[k] <= 1'b0;
      repeat (6) @(posedge clk);
      rd(12'h050, 32'h1 << k);
      rd(12'h050, 32'h0);
      `CHK(irq, m[k]);
      wr(12'h080, 32'hffff);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0);
    end
    sel_run(8'h00);
    sel_run(8'h20);
    sel_run(8'h11);
    sel_run(8'h31);
    sel_run(8'h62);
    sel_run(8'h73);
    sel_run(8'h84);
    sel_run(8'ha4);
    sel_run(8'h95);
    sel_run(8'hb5);
    sel_run(8'he6);
    sel_run(8'h40);
    div_run(4'h0, 1);
    div_run(4'h4, 2);
    div_run(4'h8, 4);
    div_run(4'h9, 16);
    div_run(4'hc, 5);
    div_run(4'hd, 10);
    div_run(4'he, 20);
    div_run(4'hf, 25);
    div_run(4'h1, 4);
    run(10'h000, 0, 8, 0);
    `CHK({pins_p, pins_n}, 2'b01);
    run(10'h300, 0, 8, 0);
    `CHK({awake, pins_p, pins_n}, 3'b000);
    wr(12'h054, 32'h280);
    repeat (4) @(posedge clk);
    `CHK(awake, 1'b1);
    stop_test();
  end
endmodule // test_hs_status_and_clock_output

bind hscl_top hscl_checker i_chk (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .tx_group3_aligned(tx_group3_aligned),
  .rx_group0_aligned(rx_group0_aligned),
  .main_rx_fifo_overrun(main_rx_fifo_overrun),
  .main_rx_fifo_underrun(main_rx_fifo_underrun),
  .alt_rx_fifo_underrun(alt_rx_fifo_underrun),
  .alt_rx_selected(alt_rx_selected),
  .clock_output_pins_p(clock_output_pins_p),
  .clock_output_pins_n(clock_output_pins_n),
  .clock_output_awake(clock_output_awake));
